// >>> hw/erf_rx_filter.sv
// receive address filter, option mask, slot table and saturating statistics counters
// assumes ports from logic on clk_in, except the nv address and jumper pins
`timescale 1ns/1ps
module erf_rx_filter #(
    parameter int NUM_GROUP = erf_pkg::GROUP_SLOTS
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    // configuration
    input  wire logic [7:0]          opt_mask_in,
    input  wire erf_pkg::erf_mode_t  net_mode_in,
    input  wire logic [47:0]         nv_station_addr_in,
    input  wire logic                sqe_check_en_in,
    output logic                     medium_en_out,
    // received frame descriptors
    input  wire logic                rx_valid_in,
    output logic                     rx_ready_out,
    input  wire logic [47:0]         rx_dest_in,
    input  wire logic                rx_align_err_in,
    input  wire logic                rx_crc_err_in,
    input  wire logic                rx_trunc_in,
    input  wire logic                rx_short_buf_in,
    input  wire logic                rx_buf_avail_in,
    input  wire logic                rx_hash_hit_in,
    // receive completions
    output logic                     cmp_valid_out,
    input  wire logic                cmp_ready_in,
    output logic [7:0]               cmp_status_out,
    output logic [7:0]               cmp_slot_out,
    // transmit requests and results
    input  wire logic                tx_req_valid_in,
    output logic                     tx_req_ready_out,
    output logic                     tx_start_out,
    output logic                     tx_fake_ok_out,
    input  wire logic                tx_sent_in,
    input  wire logic                tx_abort16_in,
    input  wire logic                tx_sqe_miss_in,
    // slot address access call and slot receive enable call
    input  wire logic                slot_valid_in,
    output logic                     slot_ready_out,
    input  wire erf_pkg::erf_slot_op_t slot_op_in,
    input  wire logic [7:0]          slot_idx_in,
    input  wire logic [47:0]         slot_addr_in,
    output logic                     slot_rsp_valid_out,
    output logic                     slot_rsp_ok_out,
    output logic [47:0]              slot_rsp_addr_out,
    output logic                     slot_rsp_en_out,
    // counter access call
    input  wire logic                cnt_valid_in,
    output logic                     cnt_busy_out,
    input  wire logic                cnt_clear_in,
    input  wire logic [2:0]          cnt_first_in,
    input  wire logic [3:0]          cnt_num_in,
    output logic                     cnt_rsp_valid_out,
    output logic [2:0]               cnt_rsp_idx_out,
    output logic [31:0]              cnt_rsp_data_out,
    output logic                     cnt_rsp_last_out
);
    import erf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and option/mode capture

    logic [47:0] nv_s1_reg, nv_s2_reg;
    logic        sqe_s1_reg, sqe_s2_reg;
    logic [7:0]  opt_reg;
    erf_mode_t   mode_reg;

    // pins pass two flops; mode and options lag one cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nv_s1_reg  <= ADDR_EMPTY;
            nv_s2_reg  <= ADDR_EMPTY;
            sqe_s1_reg <= 1'b0;
            sqe_s2_reg <= 1'b0;
            opt_reg    <= OPT_RESET;
            mode_reg   <= MODE_OFF;
        end else begin
            nv_s1_reg  <= nv_station_addr_in;
            nv_s2_reg  <= nv_s1_reg;
            sqe_s1_reg <= sqe_check_en_in;
            sqe_s2_reg <= sqe_s1_reg;
            opt_reg    <= opt_mask_in;
            mode_reg   <= net_mode_in;
        end
    end

    // one bit per flag, so any OR works
    wire opt_align  = opt_reg[OPT_ALIGN_BIT];
    wire opt_crc    = opt_reg[OPT_CRC_BIT];
    wire opt_netdis = opt_reg[OPT_NETDIS_BIT];
    wire on_net     = (mode_reg != MODE_OFF);
    wire live       = on_net && !opt_netdis;

    ////////////////////////////////////////////////////////////////////////////////
    // slot table

    logic [47:0]          addr_mem [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] en_reg;
    logic [1:0]           load_reg;

    // group slots need the group bit, the station slot needs it clear
    function automatic logic slot_write_ok(input logic [7:0] idx, input logic [47:0] a);
        logic grp;
        grp = (idx >= SLOT_GROUP_1ST) && (32'(idx) <= NUM_GROUP);
        if (grp)
            slot_write_ok = a[GROUP_BIT];
        else if (idx == SLOT_STATION)
            slot_write_ok = !a[GROUP_BIT];
        else
            slot_write_ok = 1'b0; // null, universal, broadcast, unused
    endfunction

    // lowest enabled matching group slot
    function automatic logic [7:0] first_hit(input logic [NUM_SLOTS-1:0] v);
        first_hit = SLOT_NULL;
        for (int k = NUM_SLOTS - 1; k > 0; k--) begin
            if (v[k])
                first_hit = 8'(k);
        end
    endfunction

    logic [NUM_SLOTS-1:0] grp_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_hit
            if (g >= 1 && g <= NUM_GROUP) begin : g_grp
                assign grp_hit[g] = en_reg[g] && (addr_mem[g] == rx_dest_in);
            end else begin : g_none
                assign grp_hit[g] = 1'b0;
            end
        end
    endgenerate

    wire slot_take  = slot_valid_in && slot_ready_out;
    wire wr_req     = slot_take && (slot_op_in == SOP_WRITE);
    wire wr_ok      = slot_write_ok(slot_idx_in, slot_addr_in);
    wire en_req     = slot_take && (slot_op_in == SOP_ENABLE);
    wire dis_req    = slot_take && (slot_op_in == SOP_DISABLE);
    wire rsp_ok     = (slot_op_in == SOP_WRITE) ? wr_ok : 1'b1;

    // table update; reset gives empty groups, 253 and 255 enabled
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int k = 0; k < NUM_SLOTS; k++) begin
                addr_mem[k] <= ADDR_EMPTY;
            end
            addr_mem[SLOT_BCAST]   <= ADDR_BCAST;
            en_reg                 <= '0;
            en_reg[SLOT_STATION]   <= 1'b1;
            en_reg[SLOT_BCAST]     <= 1'b1;
            load_reg               <= LOAD_WAIT;
        end else begin
            if (load_reg != LOAD_DONE)
                load_reg <= load_reg - 2'h1;
            // station address caught after sync, never at reset itself
            if (load_reg == LOAD_NOW)
                addr_mem[SLOT_STATION] <= nv_s2_reg;
            if (wr_req && wr_ok) begin
                addr_mem[slot_idx_in] <= slot_addr_in;
                en_reg[slot_idx_in]   <= 1'b0;
            end
            // enable changes touch only the flag
            if (en_req)
                en_reg[slot_idx_in] <= 1'b1;
            if (dis_req)
                en_reg[slot_idx_in] <= 1'b0;
        end
    end

    // slot call responses, one cycle after the call
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slot_ready_out     <= 1'b0;
            slot_rsp_valid_out <= 1'b0;
            slot_rsp_ok_out    <= 1'b0;
            slot_rsp_addr_out  <= ADDR_EMPTY;
            slot_rsp_en_out    <= 1'b0;
        end else begin
            slot_ready_out     <= (load_reg == LOAD_DONE);
            slot_rsp_valid_out <= slot_take;
            if (slot_take) begin
                slot_rsp_ok_out   <= rsp_ok;
                slot_rsp_addr_out <= addr_mem[slot_idx_in];
                slot_rsp_en_out   <= en_reg[slot_idx_in];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // filter decision

    wire       rx_take  = rx_valid_in && rx_ready_out;
    wire       is_bc    = (rx_dest_in == ADDR_BCAST);
    wire       is_grp   = rx_dest_in[GROUP_BIT];
    wire       st_hit   = en_reg[SLOT_STATION] && (rx_dest_in == addr_mem[SLOT_STATION]);
    wire       bc_hit   = is_bc && en_reg[SLOT_BCAST];
    wire [7:0] grp_slot = first_hit(grp_hit);
    wire       grp_pass = (mode_reg == MODE_PERFECT) ? (grp_slot != SLOT_NULL)
                        : (mode_reg == MODE_IMPERFECT) && rx_hash_hit_in;

    // universal slot when promiscuous or hash-only group
    wire [7:0] hit_slot = (mode_reg == MODE_PROMISC) ? SLOT_UNIVERSAL
                        : bc_hit ? SLOT_BCAST
                        : st_hit ? SLOT_STATION
                        : (mode_reg == MODE_IMPERFECT) ? SLOT_UNIVERSAL
                        : grp_slot;
    wire       pass     = live && ((mode_reg == MODE_PROMISC) || bc_hit || st_hit
                                   || (is_grp && !is_bc && grp_pass));

    // align and crc error frames need their own option
    wire err_ok    = (!rx_align_err_in || opt_align)
                  && (!rx_crc_err_in || opt_crc);
    wire accept    = rx_take && pass && err_ok;
    wire lost      = accept && !rx_buf_avail_in;
    wire deliver   = accept && rx_buf_avail_in;
    wire [7:0] st  = rx_short_buf_in ? ST_SHORT
                   : rx_align_err_in ? ST_ALIGN
                   : rx_crc_err_in   ? ST_CRC
                   : rx_trunc_in     ? ST_TRUNC
                   : ST_GOOD;

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry completion buffer: output stage plus skid entry

    logic       skid_v_reg;
    logic [7:0] skid_st_reg, skid_slot_reg;
    wire        out_free = !cmp_valid_out || cmp_ready_in;

    // registered ready: the skid catches the word in flight
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_valid_out  <= 1'b0;
            cmp_status_out <= ST_GOOD;
            cmp_slot_out   <= SLOT_NULL;
            skid_v_reg     <= 1'b0;
            skid_st_reg    <= ST_GOOD;
            skid_slot_reg  <= SLOT_NULL;
            rx_ready_out   <= 1'b0;
        end else begin
            if (out_free) begin
                if (skid_v_reg) begin
                    cmp_valid_out  <= 1'b1;
                    cmp_status_out <= skid_st_reg;
                    cmp_slot_out   <= skid_slot_reg;
                    skid_v_reg     <= 1'b0;
                end else begin
                    cmp_valid_out  <= deliver;
                    cmp_status_out <= st;
                    cmp_slot_out   <= hit_slot;
                end
            end else if (deliver) begin
                skid_v_reg    <= 1'b1;
                skid_st_reg   <= st;
                skid_slot_reg <= hit_slot;
            end
            rx_ready_out <= !(skid_v_reg ? !out_free : (!out_free && deliver));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit request handling and medium enable

    wire tx_take = tx_req_valid_in && tx_req_ready_out;

    // net disable still drains and reports success
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_req_ready_out <= 1'b0;
            tx_start_out     <= 1'b0;
            tx_fake_ok_out   <= 1'b0;
            medium_en_out    <= 1'b0;
        end else begin
            tx_req_ready_out <= (net_mode_in != MODE_OFF);
            tx_start_out     <= tx_take && live;
            tx_fake_ok_out   <= tx_take && opt_netdis;
            medium_en_out    <= live;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // statistics counters

    logic [NUM_CNT-1:0] ev;
    assign ev[CNT_TXOK] = tx_sent_in;
    assign ev[CNT_ABRT] = tx_abort16_in;
    assign ev[CNT_SQE]  = tx_sqe_miss_in && sqe_s2_reg;
    assign ev[CNT_RSVD] = 1'b0;
    assign ev[CNT_RXOK] = deliver && (st == ST_GOOD);
    assign ev[CNT_ALGN] = rx_take && live && rx_align_err_in;
    assign ev[CNT_CRCE] = rx_take && live && rx_crc_err_in;
    assign ev[CNT_LOST] = lost;

    erf_cst_t   cst_reg;
    logic [2:0] cidx_reg, clast_reg;
    logic       cclr_reg;
    logic [CNT_W-1:0] cnt_reg [NUM_CNT];

    wire        cnt_take = cnt_valid_in && !cnt_busy_out && (cnt_num_in != 4'h0);
    wire [4:0]  last_w   = 5'(cnt_first_in) + 5'(cnt_num_in) - 5'h1;
    wire [2:0]  last_c   = (last_w[4:3] != 2'h0) ? 3'(NUM_CNT - 1) : last_w[2:0];
    wire        run      = (cst_reg == CST_RUN);

    // set beats clear unless saturated: an event while clearing leaves one
    genvar c;
    generate
        for (c = 0; c < NUM_CNT; c++) begin : g_cnt
            wire clr = run && cclr_reg && (cidx_reg == 3'(c));
            wire inc = ev[c] && (cnt_reg[c] != '1);
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in)
                    cnt_reg[c] <= '0;
                else if (inc)
                    cnt_reg[c] <= clr ? CNT_W'(1) : cnt_reg[c] + CNT_W'(1);
                else if (clr)
                    cnt_reg[c] <= '0;
            end
        end
    endgenerate

    // range walk, one word per cycle, value taken before the clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cst_reg           <= CST_IDLE;
            cidx_reg          <= CNT_TXOK;
            clast_reg         <= CNT_TXOK;
            cclr_reg          <= 1'b0;
            cnt_busy_out      <= 1'b0;
            cnt_rsp_valid_out <= 1'b0;
            cnt_rsp_idx_out   <= CNT_TXOK;
            cnt_rsp_data_out  <= '0;
            cnt_rsp_last_out  <= 1'b0;
        end else begin
            cnt_rsp_valid_out <= run;
            cnt_rsp_last_out  <= run && (cidx_reg == clast_reg);
            if (run) begin
                cnt_rsp_idx_out  <= cidx_reg;
                cnt_rsp_data_out <= cnt_reg[cidx_reg];
            end
            case (cst_reg)
                CST_IDLE: begin
                    if (cnt_take) begin
                        cst_reg      <= CST_RUN;
                        cidx_reg     <= cnt_first_in;
                        clast_reg    <= last_c;
                        cclr_reg     <= cnt_clear_in;
                        cnt_busy_out <= 1'b1;
                    end
                end
                CST_RUN: begin
                    if (cidx_reg == clast_reg) begin
                        cst_reg      <= CST_IDLE;
                        cnt_busy_out <= 1'b0;
                    end else begin
                        cidx_reg <= cidx_reg + 3'h1;
                    end
                end
                default: begin
                    cst_reg      <= CST_IDLE;
                    cnt_busy_out <= 1'b0;
                end
            endcase
        end
    end

endmodule

// >>> hw/erf_pkg.sv
// constants, enums and slot/counter map of the receive filter
// assumes one controller clock; all users import the whole package
package erf_pkg;
    // option mask bit positions
    localparam int OPT_ALIGN_BIT  = 4;
    localparam int OPT_CRC_BIT    = 5;
    localparam int OPT_NETDIS_BIT = 7;
    localparam logic [7:0] OPT_RESET = 8'h00;
    // completion status codes
    localparam logic [7:0] ST_GOOD  = 8'h00;
    localparam logic [7:0] ST_TRUNC = 8'h04;
    localparam logic [7:0] ST_ALIGN = 8'h10;
    localparam logic [7:0] ST_CRC   = 8'h20;
    localparam logic [7:0] ST_SHORT = 8'h40;
    // slot numbers
    localparam logic [7:0] SLOT_NULL      = 8'h00;
    localparam logic [7:0] SLOT_GROUP_1ST = 8'h01;
    localparam logic [7:0] SLOT_STATION   = 8'hfd;
    localparam logic [7:0] SLOT_UNIVERSAL = 8'hfe;
    localparam logic [7:0] SLOT_BCAST     = 8'hff;
    localparam int         NUM_SLOTS      = 256;
    localparam int         GROUP_SLOTS    = 252;
    localparam logic [47:0] ADDR_EMPTY    = 48'h0000_0000_0000;
    localparam logic [47:0] ADDR_BCAST    = 48'hffff_ffff_ffff;
    // group flag: lsb of the first octet sent, octet 0 in bits 47:40
    localparam int GROUP_BIT = 40;
    // statistics
    localparam int         CNT_W    = 32;
    localparam int         NUM_CNT  = 8;
    localparam logic [2:0] CNT_TXOK = 3'h0;
    localparam logic [2:0] CNT_ABRT = 3'h1;
    localparam logic [2:0] CNT_SQE  = 3'h2;
    localparam logic [2:0] CNT_RSVD = 3'h3;
    localparam logic [2:0] CNT_RXOK = 3'h4;
    localparam logic [2:0] CNT_ALGN = 3'h5;
    localparam logic [2:0] CNT_CRCE = 3'h6;
    localparam logic [2:0] CNT_LOST = 3'h7;
    // station load countdown; the sync stages must fill first
    localparam logic [1:0] LOAD_WAIT = 2'h3;
    localparam logic [1:0] LOAD_NOW  = 2'h1;
    localparam logic [1:0] LOAD_DONE = 2'h0;

    typedef enum logic [1:0] {
        MODE_OFF       = 2'b00,
        MODE_PERFECT   = 2'b01,
        MODE_IMPERFECT = 2'b10,
        MODE_PROMISC   = 2'b11
    } erf_mode_t;

    typedef enum logic [1:0] {
        SOP_READ    = 2'b00,
        SOP_WRITE   = 2'b01,
        SOP_ENABLE  = 2'b10,
        SOP_DISABLE = 2'b11
    } erf_slot_op_t;

    typedef enum logic {
        CST_IDLE = 1'b0,
        CST_RUN  = 1'b1
    } erf_cst_t;
endpackage

// >>> verification/erf_medium_model.sv
// medium stand-in: answers each transmit start with one result pulse, sent plus sqe miss together for kind_in 2
// assumes kind_in steady during a transmit
`timescale 1ns/1ps
module erf_medium_model #(
    parameter int DLY = 4
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       tx_start_in,
    input  wire logic [1:0] kind_in,
    output logic            tx_sent_out,
    output logic            tx_abort16_out,
    output logic            tx_sqe_miss_out
);
    int cnt_reg;
    // sqe misses answer late, so both speeds are seen
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 0;
        end else if (tx_start_in) begin
            cnt_reg <= (kind_in == 2'h2) ? 2 * DLY : DLY;
        end else if (cnt_reg != 0) begin
            cnt_reg <= cnt_reg - 1;
        end
    end
    // one-cycle result pulses
    assign tx_sent_out     = (cnt_reg == 1) && (kind_in != 2'h1);
    assign tx_abort16_out  = (cnt_reg == 1) && (kind_in == 2'h1);
    assign tx_sqe_miss_out = (cnt_reg == 1) && (kind_in == 2'h2);
endmodule

// >>> verification/erf_chk.sv
// port checker, bound into the filter's top module
// assumes one clock and the filter's group slot count
`timescale 1ns/1ps
module erf_chk import erf_pkg::*; #(parameter int NUM_GROUP = GROUP_SLOTS) (
    input wire logic clk_in, rstn_in, medium_en_out, cmp_valid_out, cmp_ready_in, tx_req_valid_in,
    input wire logic tx_req_ready_out, tx_start_out, tx_fake_ok_out, slot_valid_in, slot_ready_out,
    input wire logic slot_rsp_valid_out, slot_rsp_ok_out, cnt_valid_in, cnt_busy_out, cnt_rsp_valid_out,
    input wire logic cnt_rsp_last_out,
    input wire logic [7:0] opt_mask_in, cmp_status_out, cmp_slot_out, slot_idx_in,
    input wire erf_pkg::erf_mode_t net_mode_in,
    input wire erf_pkg::erf_slot_op_t slot_op_in,
    input wire logic [47:0] slot_addr_in,
    input wire logic [3:0] cnt_num_in,
    input wire logic [2:0] cnt_first_in, cnt_rsp_idx_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // write taken, refused answer
    wire wr  = slot_valid_in && slot_ready_out && slot_op_in == SOP_WRITE;
    wire rej = slot_rsp_valid_out && !slot_rsp_ok_out;
    wire txt = tx_req_valid_in && tx_req_ready_out;
    a_bcast_locked: assert property (wr && slot_idx_in == SLOT_BCAST |=> rej)
        else $error("broadcast slot write accepted");
    a_group_only: assert property (wr && slot_idx_in >= 8'h01 && slot_idx_in <= NUM_GROUP
        && !slot_addr_in[GROUP_BIT] |=> rej) else $error("individual address in group slot");
    a_station_indiv: assert property (wr && slot_idx_in == SLOT_STATION && slot_addr_in[GROUP_BIT] |=> rej)
        else $error("group address in station slot");
    a_status_code: assert property (cmp_valid_out |-> cmp_status_out inside {8'h00, 8'h04, 8'h10, 8'h20, 8'h40})
        else $error("unknown completion status");
    a_cmp_hold: assert property (cmp_valid_out && !cmp_ready_in |=> cmp_valid_out
        && $stable(cmp_status_out) && $stable(cmp_slot_out)) else $error("completion dropped while stalled");
    a_netdis_tx: assert property (txt && opt_mask_in[OPT_NETDIS_BIT] && $past(opt_mask_in[OPT_NETDIS_BIT])
        |=> tx_fake_ok_out && !tx_start_out) else $error("net disable transmit not faked");
    a_off_silent: assert property (net_mode_in == MODE_OFF [*3] |-> !medium_en_out && !tx_req_ready_out)
        else $error("medium live while off net");
    a_netdis_quiet: assert property (opt_mask_in[OPT_NETDIS_BIT] [*3] |-> !medium_en_out)
        else $error("medium live under net disable");
    a_cnt_first: assert property (cnt_valid_in && !cnt_busy_out && cnt_num_in != 4'h0 |=> cnt_busy_out
        ##1 (cnt_rsp_valid_out && cnt_rsp_idx_out == $past(cnt_first_in, 2))) else $error("counter access late");
    a_cnt_last: assert property (cnt_rsp_valid_out && cnt_rsp_idx_out == 3'h7 |-> cnt_rsp_last_out)
        else $error("range not clipped at last counter");
    c_bcast: cover property (cmp_valid_out && cmp_slot_out == SLOT_BCAST);
    c_cnt: cover property (cnt_rsp_valid_out && cnt_rsp_last_out);
    c_fake: cover property (tx_fake_ok_out);
endmodule

// >>> verification/erf_tb_top.sv
// testbench: slot table, frame filter, transmit and counter sequences
// assumes the medium model answers transmits
`timescale 1ns/1ps
module erf_tb_top;
    import erf_pkg::*;
    localparam logic [47:0] STA = 48'h0012_3456_789a;
    localparam logic [47:0] ST2 = 48'h0012_3456_0001;
    localparam logic [47:0] GRP = 48'h0100_5e00_0001;
    logic clk_in = 0, rstn_in = 0, rx_valid_in = 0, cmp_ready_in = 1, tx_req_valid_in = 0, cnt_clear_in = 0;
    logic slot_valid_in = 0, cnt_valid_in = 0, sqe_check_en_in = 1, ok_r, en_r;
    logic rx_align_err_in = 0, rx_crc_err_in = 0, rx_trunc_in = 0, rx_short_buf_in = 0;
    logic rx_buf_avail_in = 0, rx_hash_hit_in = 0, medium_en_out, rx_ready_out, cmp_valid_out;
    logic tx_req_ready_out, tx_start_out, tx_fake_ok_out, tx_sent_in, tx_abort16_in, tx_sqe_miss_in;
    logic slot_ready_out, slot_rsp_valid_out, slot_rsp_ok_out, slot_rsp_en_out, cnt_busy_out;
    logic cnt_rsp_valid_out, cnt_rsp_last_out;
    logic [7:0] opt_mask_in = '0, slot_idx_in = '0, cmp_status_out, cmp_slot_out;
    logic [47:0] rx_dest_in = '0, slot_addr_in = '0, nv_station_addr_in = STA, slot_rsp_addr_out, ad_r;
    logic [2:0] cnt_first_in = '0, cnt_rsp_idx_out;
    logic [3:0] cnt_num_in = '0;
    logic [1:0] kind = 2'h0;
    logic [31:0] cnt_rsp_data_out, cv [8];
    erf_mode_t net_mode_in = MODE_OFF;
    erf_slot_op_t slot_op_in = SOP_READ;
    int n_errors = 0, n_tests = 0, cyc = 0, n = 0, ev [8];
    erf_rx_filter erf_rx_filter_inst (.*);
    erf_medium_model erf_medium_model_inst (.clk_in, .rstn_in, .tx_start_in(tx_start_out),
        .kind_in(kind), .tx_sent_out(tx_sent_in), .tx_abort16_out(tx_abort16_in), .tx_sqe_miss_out(tx_sqe_miss_in));
    initial forever #25 clk_in = ~clk_in;
    task automatic ck(input logic [48:0] g, input logic [48:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // bounded wait for a high sample at an edge
    task automatic hs(ref logic s);
        int w = 0;
        do @(posedge clk_in); while (s !== 1'b1 && ++w < 60);
    endtask
    task automatic slt(input erf_slot_op_t op, input logic [7:0] ix, input logic [47:0] a);
        slot_op_in = op;
        slot_idx_in = ix;
        slot_addr_in = a;
        slot_valid_in = 1;
        hs(slot_ready_out);
        #1 slot_valid_in = 0;
        hs(slot_rsp_valid_out);
        {ok_r, en_r, ad_r} = {slot_rsp_ok_out, slot_rsp_en_out, slot_rsp_addr_out};
        #1;
    endtask
    task automatic rd(input logic [7:0] ix, input logic e, input logic [47:0] a);
        slt(SOP_READ, ix, '0);
        ck({ok_r, en_r, ad_r}, {1'b1, e, a});
    endtask
    // flags: align, crc, trunc, short, buffer free, hash
    task automatic frm(input logic [47:0] d, input logic [5:0] f);
        rx_dest_in = d;
        {rx_align_err_in, rx_crc_err_in, rx_trunc_in, rx_short_buf_in, rx_buf_avail_in, rx_hash_hit_in} = f;
        rx_valid_in = 1;
        hs(rx_ready_out);
        #1;
    endtask
    task automatic exp(input logic [7:0] st, input logic [7:0] sl);
        rx_valid_in = 0;
        hs(cmp_valid_out);
        ck({cmp_valid_out, cmp_status_out, cmp_slot_out}, {1'b1, st, sl});
        #1;
    endtask
    task automatic non();
        rx_valid_in = 0;
        repeat (6) begin
            @(posedge clk_in);
            ck(cmp_valid_out, 0);
        end
        #1;
    endtask
    // mode and options are registered; settle before traffic
    task automatic md(input erf_mode_t m, input logic [7:0] o);
        net_mode_in = m;
        opt_mask_in = o;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic cnt(input logic [2:0] f, input logic [3:0] k, input logic c);
        {cnt_first_in, cnt_num_in, cnt_clear_in, cnt_valid_in} = {f, k, c, 1'b1};
        @(posedge clk_in);
        #1 cnt_valid_in = 0;
        do begin
            hs(cnt_rsp_valid_out);
            cv[cnt_rsp_idx_out] = cnt_rsp_data_out;
        end while (cnt_rsp_last_out !== 1'b1);
        #1;
    endtask
    task automatic tx(input logic [1:0] k, input logic fk);
        kind = k;
        tx_req_valid_in = 1;
        hs(tx_req_ready_out);
        #1 tx_req_valid_in = 0;
        @(posedge clk_in);
        ck({tx_fake_ok_out, tx_start_out}, {fk, !fk});
        repeat (12) @(posedge clk_in);
        #1;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard, well above the run length
    always @(posedge clk_in) begin
        if (++cyc >= 10000) begin
            n_errors++;
            $display("ERROR t=%0t timeout", $time);
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rstn_in = 1;
        cnt(3'h0, 4'h8, 0);
        foreach (cv[i]) ck(cv[i], 0);
        rd(SLOT_STATION, 1, STA);
        rd(SLOT_BCAST, 1, ADDR_BCAST);
        rd(SLOT_GROUP_1ST, 0, ADDR_EMPTY);
        slt(SOP_WRITE, SLOT_STATION, ST2);
        rd(SLOT_STATION, 0, ST2);
        slt(SOP_ENABLE, SLOT_STATION, '0);
        rd(SLOT_STATION, 1, ST2);
        slt(SOP_WRITE, SLOT_GROUP_1ST, GRP);
        slt(SOP_ENABLE, SLOT_GROUP_1ST, '0);
        slt(SOP_WRITE, 8'h02, STA);
        ck(ok_r, 0);
        slt(SOP_WRITE, SLOT_STATION, GRP);
        ck(ok_r, 0);
        slt(SOP_WRITE, SLOT_BCAST, '0);
        ck(ok_r, 0);
        slt(SOP_DISABLE, 8'h02, '0);
        ck(ok_r, 1);
        $display("test slots done");
        md(MODE_PERFECT, 8'h00);
        frm(GRP, 6'h02);
        exp(ST_GOOD, SLOT_GROUP_1ST);
        frm(ADDR_BCAST, 6'h02);
        exp(ST_GOOD, SLOT_BCAST);
        frm(ST2, 6'h02);
        exp(ST_GOOD, SLOT_STATION);
        frm(ST2, 6'h12);
        non();
        frm(ST2, 6'h0a);
        exp(ST_TRUNC, SLOT_STATION);
        frm(ST2, 6'h06);
        exp(ST_SHORT, SLOT_STATION);
        md(MODE_PERFECT, 8'h20);
        frm(ST2, 6'h12);
        exp(ST_CRC, SLOT_STATION);
        md(MODE_PERFECT, 8'h30);
        frm(ST2, 6'h22);
        exp(ST_ALIGN, SLOT_STATION);
        frm(ST2, 6'h00);
        non();
        md(MODE_PROMISC, 8'h00);
        frm(48'h0200_0000_0001, 6'h02);
        exp(ST_GOOD, SLOT_UNIVERSAL);
        md(MODE_IMPERFECT, 8'h00);
        frm(48'h0300_0000_0099, 6'h03);
        exp(ST_GOOD, SLOT_UNIVERSAL);
        $display("test frames done");
        md(MODE_PERFECT, 8'h00);
        cmp_ready_in = 0;
        while (n < 6 && rx_ready_out === 1'b1) begin
            frm(ST2, 6'h02);
            n++;
        end
        ck(rx_ready_out, 0);
        cmp_ready_in = 1;
        repeat (n) exp(ST_GOOD, SLOT_STATION);
        tx(2'h0, 0);
        tx(2'h1, 0);
        tx(2'h2, 0);
        cnt(3'h0, 4'h8, 1);
        ev = '{2, 1, 1, 0, 5 + n, 1, 2, 1};
        foreach (ev[i]) ck(cv[i], ev[i]);
        cnt(3'h5, 4'h6, 0);
        for (int i = 5; i < 8; i++) ck(cv[i], 0);
        $display("test counters done");
        md(MODE_PERFECT, 8'h80);
        ck(medium_en_out, 0);
        tx(2'h0, 1);
        frm(ST2, 6'h02);
        non();
        $display("test net disable done");
        print_verdict();
    end
endmodule
bind erf_rx_filter erf_chk #(.NUM_GROUP(NUM_GROUP)) erf_chk_inst (.*);
